// file: mbs_pkg.sv
// Constants, codes and helpers for the serial-line register server core.
// Assumes one 20 MHz clock; character timing and the UART live outside.
package mbs_pkg;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam longint CLK_HZ     = 20_000_000;
  localparam longint LINE_BAUD  = 19_200;
  localparam longint CHAR_BITS  = 11;   // Start, 8 data, parity, stop.
  // Idle time that ends a frame, 3.5 characters, in ns (rounded up).
  localparam longint T35_NS     = (35 * CHAR_BITS * 1_000_000_000 + 10 * LINE_BAUD - 1)
                                  / (10 * LINE_BAUD);
  // Least time, so the cycle count rounds up.
  localparam int unsigned T35_CYCLES = int'((T35_NS * CLK_HZ + 999_999_999) / 1_000_000_000);
  localparam int GAP_W = 16;

  // ------------------------------------------------------------------
  // Line defaults and function codes
  // ------------------------------------------------------------------
  localparam logic [15:0] LINE_BAUD_DEF = 16'h4b00;  // 19200 bit/s.
  localparam logic [1:0]  PARITY_EVEN   = 2'h2;
  localparam logic        STOP_ONE      = 1'h0;
  localparam logic [7:0]  FC_RD_HOLD    = 8'h03;
  localparam logic [7:0]  FC_RD_IN      = 8'h04;
  localparam logic [7:0]  FC_WR_ONE     = 8'h06;
  localparam logic [7:0]  FC_WR_MANY    = 8'h10;
  localparam logic [7:0]  EXC_FLAG      = 8'h80;
  localparam logic [7:0]  EXC_FUNC      = 8'h01;
  localparam logic [7:0]  EXC_ADDR      = 8'h02;
  localparam logic [7:0]  EXC_VALUE     = 8'h03;
  localparam logic [15:0] MAX_RD        = 16'h007d;  // 125 registers.
  localparam logic [15:0] MAX_WR        = 16'h007b;  // 123 registers.
  localparam logic [7:0]  BCAST_ADDR    = 8'h00;
  localparam logic [15:0] CRC_INIT      = 16'hffff;
  localparam logic [15:0] CRC_POLY      = 16'ha001;

  // ------------------------------------------------------------------
  // Frame buffer layout
  // ------------------------------------------------------------------
  localparam int          BUF_DEPTH   = 256;
  localparam int          FIFO_DEPTH  = 8;
  localparam logic [8:0]  MIN_LEN     = 9'h004;
  localparam logic [8:0]  LEN_FIXED   = 9'h008;  // Read or single write request.
  localparam logic [8:0]  LEN_WR_HEAD = 9'h009;
  localparam logic [8:0]  LEN_EXC     = 9'h003;
  localparam logic [8:0]  LEN_ECHO    = 9'h006;
  localparam logic [8:0]  LEN_RD_HEAD = 9'h003;
  localparam logic [8:0]  OFF_RD_DATA = 9'h003;
  localparam logic [8:0]  OFF_WR_ONE  = 9'h004;
  localparam logic [8:0]  OFF_WR_MANY = 9'h007;

  // One byte step of the reflected CRC-16.
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

endpackage

// file: mbs_stream_if.sv
// Valid/ready byte stream between the core and its transmit FIFO.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface mbs_stream_if #(parameter int W = 8);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;
  modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

// file: mbs_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes a single clock; full and empty come from pointers with a wrap bit.
`timescale 1ns/1ps
module mbs_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic clk,
  input  wire logic rst,
  mbs_stream_if.fifo s
);
  import mbs_pkg::*;
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0]         wp;
    logic [AW:0]         rp;
  } mbs_fifo_s;

  mbs_fifo_s f_reg;
  mbs_fifo_s f_next;
  logic      full;
  logic      empty;

  // ------------------------------------------------------------------
  // Flags and handshakes
  // ------------------------------------------------------------------
  // Full when the pointers differ only in the wrap bit.
  assign full        = (f_reg.wp[AW] != f_reg.rp[AW]) && (f_reg.wp[AW-1:0] == f_reg.rp[AW-1:0]);
  assign empty       = (f_reg.wp == f_reg.rp);
  assign s.in_ready  = !full;
  assign s.out_valid = !empty;
  assign s.out_data  = f_reg.mem[f_reg.rp[AW-1:0]];

  // Pointer and storage update.
  always_comb begin
    f_next = f_reg;
    if (s.in_valid && !full) begin
      f_next.mem[f_reg.wp[AW-1:0]] = s.in_data;
      f_next.wp = f_reg.wp + 1'b1;
    end
    if (s.out_ready && !empty) begin
      f_next.rp = f_reg.rp + 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      f_reg <= '0;
    end else begin
      f_reg <= f_next;
    end
  end
endmodule

// file: mbs_core.sv
// Serial-line register server: request parser, register access, reply builder.
// Assumes a UART on clk delivering bytes and an external register map port.
//
// Overview of operation
// R1: Transmit only as the reply to a received, checked request; never unprompted.
// R2: Function 3 reads count holding registers from the start address upward.
// R3: Function 4 reads 1 to 125 consecutive input registers.
// R4: Function 16 writes 1 to 123 values to consecutive addresses.
// R5: Function 6 writes exactly one holding register with the given value.
// R6: Reply bytes are queued back to back with no gap inside the frame.
// R7: Frame is address byte, function code and data, then CRC.
// R8: Unprocessable request answers with function code plus 0x80 and a code.
// R9: Registers are 16 bits; input registers are never written.
// R10: Line comes up at 19200 bit/s, 8 data, even parity, one stop.
// R11: CRC-16 reflected 0xa001, init 0xffff, low byte first; 3.5-char gaps.
`timescale 1ns/1ps
module mbs_core #(
  parameter int unsigned T35_CYC = mbs_pkg::T35_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  node_addr,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  input  wire logic        rx_err,
  output logic [7:0]       tx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic             tx_busy,
  output logic             reg_req,
  output logic             reg_we,
  output logic             reg_input,
  output logic [15:0]      reg_addr,
  output logic [15:0]      reg_wdata,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_ack,
  input  wire logic        reg_fault,
  output logic [15:0]      line_baud,
  output logic [1:0]       line_parity,
  output logic             line_stop2
);
  import mbs_pkg::*;

  typedef enum {ST_COLLECT, ST_CHECK, ST_ACCESS, ST_REPLY, ST_CRC_LO, ST_CRC_HI} mbs_state_e;

  typedef struct packed {
    mbs_state_e                st;
    logic [BUF_DEPTH-1:0][7:0] bufm;
    logic [8:0]                len;
    logic [GAP_W-1:0]          gap;
    logic [15:0]               rcrc;
    logic                      bad;
    logic [7:0]                fc;
    logic [7:0]                cnt;
    logic [7:0]                idx;
    logic [15:0]               addr;
    logic [8:0]                woff;
    logic                      we;
    logic                      bcast;
    logic [8:0]                ptr;
    logic [8:0]                tlen;
    logic [15:0]               tcrc;
    logic [15:0]               baud;
    logic [1:0]                parity;
    logic                      stop2;
  } mbs_core_s;

  mbs_core_s   r_reg;
  mbs_core_s   r_next;
  mbs_stream_if #(.W(8)) txq ();
  logic        push;
  logic [15:0] qty;
  logic [8:0]  wlen;

  // ------------------------------------------------------------------
  // Transmit queue
  // ------------------------------------------------------------------
  // The queue absorbs a stalled UART so the reply is never torn mid-frame.
  mbs_fifo #(.W(8), .D(FIFO_DEPTH)) u_txq (
    .clk (clk),
    .rst (rst),
    .s   (txq.fifo)
  );

  // Queue and port wiring.
  assign txq.in_valid  = (r_reg.st == ST_REPLY) || (r_reg.st == ST_CRC_LO)
                         || (r_reg.st == ST_CRC_HI);  // R1
  assign txq.in_data   = (r_reg.st == ST_CRC_LO) ? r_reg.tcrc[7:0] :
                         (r_reg.st == ST_CRC_HI) ? r_reg.tcrc[15:8] :
                         r_reg.bufm[r_reg.ptr[7:0]];  // R11
  assign push          = txq.in_valid && txq.in_ready;
  assign txq.out_ready = tx_ready;
  assign tx_data       = txq.out_data;
  assign tx_valid      = txq.out_valid;
  assign tx_busy       = txq.in_valid || txq.out_valid;
  assign reg_req       = (r_reg.st == ST_ACCESS);
  assign reg_we        = r_reg.we;
  assign reg_input     = (r_reg.fc == FC_RD_IN);
  assign reg_addr      = r_reg.addr;
  assign reg_wdata     = {r_reg.bufm[r_reg.woff[7:0]], r_reg.bufm[r_reg.woff[7:0] + 8'h01]};
  assign line_baud     = r_reg.baud;
  assign line_parity   = r_reg.parity;
  assign line_stop2    = r_reg.stop2;
  assign qty           = {r_reg.bufm[4], r_reg.bufm[5]};
  assign wlen          = LEN_WR_HEAD + {1'b0, r_reg.bufm[6]};

  // ------------------------------------------------------------------
  // Request parse, register access and reply sequencing
  // ------------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    case (r_reg.st)
      // Bytes collect until the line has been idle for 3.5 characters.
      ST_COLLECT: begin
        if (rx_valid) begin
          if (r_reg.len[8]) begin
            r_next.bad = 1'b1;
          end else begin
            r_next.bufm[r_reg.len[7:0]] = rx_data;
            r_next.len = r_reg.len + 9'h001;
          end
          r_next.rcrc = crc_byte(r_reg.rcrc, rx_data);  // R11
          r_next.bad  = r_next.bad | rx_err;
          r_next.gap  = '0;
        end else if (r_reg.len != 9'h000) begin
          if (r_reg.gap == T35_CYC[GAP_W-1:0]) begin
            r_next.st = ST_CHECK;  // R11
          end else begin
            r_next.gap = r_reg.gap + 1'b1;
          end
        end
      end
      // Address, CRC and request format are judged in one cycle.
      ST_CHECK: begin
        r_next.st    = ST_COLLECT;
        r_next.fc    = r_reg.bufm[1];
        r_next.addr  = {r_reg.bufm[2], r_reg.bufm[3]};
        r_next.idx   = '0;
        r_next.bcast = (r_reg.bufm[0] == BCAST_ADDR);
        r_next.we    = 1'b0;
        r_next.cnt   = qty[7:0];
        r_next.woff  = OFF_RD_DATA;
        r_next.ptr   = '0;
        r_next.tcrc  = CRC_INIT;
        if (!r_reg.bad && r_reg.len >= MIN_LEN && r_reg.rcrc == 16'h0000
            && (r_reg.bufm[0] == node_addr || r_next.bcast)) begin  // R1 R7
          r_next.st = ST_ACCESS;
          case (r_reg.bufm[1])
            FC_RD_HOLD, FC_RD_IN: begin  // R2 R3
              if (r_reg.len != LEN_FIXED || qty == 16'h0000 || qty > MAX_RD) begin
                r_next.st = ST_REPLY;
              end
            end
            FC_WR_ONE: begin  // R5
              r_next.cnt  = 8'h01;
              r_next.we   = 1'b1;
              r_next.woff = OFF_WR_ONE;
              if (r_reg.len != LEN_FIXED) begin
                r_next.st = ST_REPLY;
              end
            end
            FC_WR_MANY: begin  // R4
              r_next.we   = 1'b1;
              r_next.woff = OFF_WR_MANY;
              if (qty == 16'h0000 || qty > MAX_WR || r_reg.len != wlen
                  || r_reg.bufm[6] != {qty[6:0], 1'b0}) begin
                r_next.st = ST_REPLY;
              end
            end
            default: r_next.st = ST_REPLY;
          endcase
          // A refused request becomes an exception reply, unless it was a broadcast.
          if (r_next.st == ST_REPLY) begin
            r_next.bufm[1] = r_reg.bufm[1] | EXC_FLAG;  // R8
            r_next.bufm[2] = (r_reg.bufm[1] == FC_RD_HOLD || r_reg.bufm[1] == FC_RD_IN
                              || r_reg.bufm[1] == FC_WR_ONE || r_reg.bufm[1] == FC_WR_MANY)
                             ? EXC_VALUE : EXC_FUNC;
            r_next.tlen = LEN_EXC;
          end
          // Read requests sent to everyone would collide, so they get no answer.
          if (r_next.bcast && (r_next.st == ST_REPLY || !r_next.we)) begin
            r_next.st = ST_COLLECT;
          end
        end
        r_next.len  = '0;
        r_next.gap  = '0;
        r_next.rcrc = CRC_INIT;
        r_next.bad  = 1'b0;
      end
      // One register per acknowledge; read data lands in the reply buffer.
      ST_ACCESS: begin
        if (reg_ack) begin
          if (reg_fault) begin
            r_next.bufm[1] = r_reg.fc | EXC_FLAG;  // R8
            r_next.bufm[2] = EXC_ADDR;
            r_next.tlen    = LEN_EXC;
            r_next.st      = r_reg.bcast ? ST_COLLECT : ST_REPLY;
          end else begin
            if (!r_reg.we) begin
              r_next.bufm[r_reg.woff[7:0]]         = reg_rdata[15:8];  // R9
              r_next.bufm[r_reg.woff[7:0] + 8'h01] = reg_rdata[7:0];
            end
            r_next.woff = r_reg.woff + 9'h002;
            r_next.addr = r_reg.addr + 16'h0001;  // R2 R4
            r_next.idx  = r_reg.idx + 8'h01;
            if (r_reg.idx == r_reg.cnt - 8'h01) begin
              r_next.bufm[2] = r_reg.we ? r_reg.bufm[2] : {r_reg.cnt[6:0], 1'b0};
              r_next.tlen    = r_reg.we ? LEN_ECHO : LEN_RD_HEAD + {r_reg.cnt, 1'b0};
              r_next.st      = r_reg.bcast ? ST_COLLECT : ST_REPLY;
              r_next.we      = 1'b0;
            end
          end
        end
      end
      // Payload then CRC, one byte per free queue slot.
      ST_REPLY: begin
        if (push) begin  // R6
          r_next.tcrc = crc_byte(r_reg.tcrc, txq.in_data);
          r_next.ptr  = r_reg.ptr + 9'h001;
          if (r_reg.ptr == r_reg.tlen - 9'h001) begin
            r_next.st = ST_CRC_LO;
          end
        end
      end
      ST_CRC_LO: begin
        if (push) begin
          r_next.st = ST_CRC_HI;  // R11
        end
      end
      ST_CRC_HI: begin
        if (push) begin
          r_next.st = ST_COLLECT;
        end
      end
      default: r_next.st = ST_COLLECT;
    endcase
  end

  // State register; the line settings come up at their defaults.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg        <= '0;
      r_reg.st     <= ST_COLLECT;
      r_reg.rcrc   <= CRC_INIT;
      r_reg.tcrc   <= CRC_INIT;
      r_reg.baud   <= LINE_BAUD_DEF;  // R10
      r_reg.parity <= PARITY_EVEN;
      r_reg.stop2  <= STOP_ONE;
    end else begin
      r_reg <= r_next;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  reply_after_req_a: assert property ($rose(r_reg.st == ST_REPLY) |->  // R1
    $past(r_reg.st) == ST_CHECK || $past(r_reg.st) == ST_ACCESS)
    else $error("Reply started without a request.");
  read_holding_a: assert property (reg_req && reg_ack && !reg_fault && !reg_we  // R2
    ##1 reg_req |-> reg_addr == $past(reg_addr) + 16'h0001)
    else $error("Read address did not advance by one.");
  read_count_a: assert property (reg_req && !reg_we |->  // R3
    r_reg.cnt >= 8'h01 && r_reg.cnt <= MAX_RD[7:0])
    else $error("Read count out of range.");
  write_count_a: assert property (reg_req && r_reg.fc == FC_WR_MANY |->  // R4
    reg_we && r_reg.cnt >= 8'h01 && r_reg.cnt <= MAX_WR[7:0])
    else $error("Block write count out of range.");
  single_write_a: assert property (reg_req && reg_ack && r_reg.fc == FC_WR_ONE |->  // R5
    ##1 r_reg.st != ST_ACCESS)
    else $error("Single write touched more than one register.");
  no_gap_a: assert property (r_reg.st == ST_REPLY && txq.in_ready |->  // R6
    txq.in_valid ##1 r_reg.st != ST_COLLECT)
    else $error("Reply stream paused while the queue had room.");
  frame_tail_a: assert property (r_reg.st == ST_CRC_LO && push |->  // R7
    ##1 r_reg.st == ST_CRC_HI && txq.in_data == $past(r_reg.tcrc[15:8]))
    else $error("CRC bytes not sent low then high.");
  exception_code_a: assert property (r_reg.st == ST_REPLY && r_reg.tlen == LEN_EXC |->  // R8
    r_reg.bufm[1][7] && r_reg.bufm[1][6:0] == r_reg.fc[6:0])
    else $error("Exception code not marked with the top bit.");
  input_ro_a: assert property (reg_req && reg_input |-> !reg_we)  // R9
    else $error("Write issued to an input register.");
  line_default_a: assert property (line_baud == LINE_BAUD_DEF && line_parity == PARITY_EVEN  // R10
    && line_stop2 == STOP_ONE)
    else $error("Line settings left their defaults.");
  frame_gap_a: assert property (r_reg.st == ST_COLLECT && rx_valid |=>  // R11
    r_reg.st == ST_COLLECT [*2])
    else $error("Frame closed without an idle gap.");
endmodule

// file: mbs_partner.sv
// Far-side model: register map behind the access port and a sink for reply bytes.
// Assumes the core's clock and reset; the map holds 128 holding registers.
`timescale 1ns/1ps
module mbs_partner (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic        reg_req,
  input  wire logic        reg_we,
  input  wire logic        reg_input,
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic [15:0]      reg_rdata,
  output logic             reg_ack,
  output logic             reg_fault,
  input  wire logic [7:0]  tx_data,
  input  wire logic        tx_valid,
  output logic             tx_ready
);
  logic [15:0] mem [128];
  logic [7:0]  got [$];
  logic [1:0]  pace;
  logic [15:0] val;
  int          gap;
  int          max_gap;

  // Input registers are a fixed pattern of the address, so no store backs them.
  assign val       = reg_input ? (reg_addr ^ 16'h5a00) : mem[reg_addr[6:0]];
  // Off the ack the bus shows the inverse, so a late sample cannot pass.
  assign reg_rdata = reg_ack ? val : ~val;
  assign reg_fault = reg_ack && ((reg_addr > 16'h007f) || (reg_we && reg_input));
  assign tx_ready  = !slow || pace[1];

  // The map powers up cleared and is not touched by a core reset.
  initial begin
    for (int i = 0; i < 128; i++) mem[i] = 16'h0000;
  end

  // Acks come every other cycle, or on every fourth edge when slow.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_ack <= 1'b0;
      pace    <= 2'h0;
    end else begin
      pace    <= pace + 2'h1;
      reg_ack <= reg_req && !reg_ack && (!slow || pace == 2'h3);
      if (reg_req && reg_ack && reg_we && !reg_fault) begin
        mem[reg_addr[6:0]] <= reg_wdata;
      end
      gap <= gap + 1;
      if (tx_valid && tx_ready) begin
        if (got.size() > 0 && gap > max_gap) max_gap <= gap;
        got.push_back(tx_data);
        gap <= 1;
      end
    end
  end
endmodule

// file: testbench.sv
// Self-checking bench for the register server core: framed requests in, replies compared.
// Assumes mbs_partner as register map and byte sink; frame gap shortened to 20 cycles.
`timescale 1ns/1ps
module testbench;
  import mbs_pkg::*;

  typedef struct packed {
    logic [7:0]  fc;
    logic [15:0] a;
    logic [15:0] n;
    logic [7:0]  x;
    logic        slow;
  } mbs_row_s;

  // --------------------------------------------------------------
  // Cases: function, start, count or value, exception, slow far side
  // --------------------------------------------------------------
  localparam logic [7:0] NODE = 8'h11;
  localparam mbs_row_s ROWS [13] = '{
    '{FC_RD_HOLD, 16'h0000, 16'h0002, 8'h00,     1'b0},
    '{FC_WR_ONE,  16'h0005, 16'hbeef, 8'h00,     1'b1},
    '{FC_RD_HOLD, 16'h0004, 16'h0003, 8'h00,     1'b1},
    '{FC_RD_IN,   16'h0000, 16'h007d, 8'h00,     1'b0},
    '{FC_RD_IN,   16'h0000, 16'h007e, EXC_VALUE, 1'b0},
    '{FC_WR_MANY, 16'h0000, 16'h007b, 8'h00,     1'b1},
    '{FC_WR_MANY, 16'h0000, 16'h007c, EXC_VALUE, 1'b0},
    '{FC_RD_HOLD, 16'h0000, 16'h0000, EXC_VALUE, 1'b0},
    '{8'h07,      16'h0000, 16'h0001, EXC_FUNC,  1'b0},
    '{FC_RD_HOLD, 16'h007e, 16'h0004, EXC_ADDR,  1'b0},
    '{FC_WR_MANY, 16'h007e, 16'h0003, EXC_ADDR,  1'b0},
    '{FC_RD_HOLD, 16'h007c, 16'h0004, 8'h00,     1'b0},
    '{FC_RD_HOLD, 16'h0000, 16'h007d, 8'h00,     1'b0}
  };

  logic        clk;
  logic        rst;
  logic        slow;
  logic [7:0]  rx_data;
  logic        rx_valid;
  logic        rx_err;
  logic [7:0]  tx_data;
  logic        tx_valid;
  logic        tx_ready;
  logic        tx_busy;
  logic        reg_req;
  logic        reg_we;
  logic        reg_input;
  logic [15:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        reg_ack;
  logic        reg_fault;
  logic [15:0] line_baud;
  logic [1:0]  line_parity;
  logic        line_stop2;
  logic [15:0] sh [128];
  int          n_fail;
  int          compares;
  int          cyc;

  mbs_core #(.T35_CYC(20)) i_mbs_core (
    .clk(clk), .rst(rst), .node_addr(NODE), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_err(rx_err), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_busy(tx_busy), .reg_req(reg_req), .reg_we(reg_we), .reg_input(reg_input),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .reg_fault(reg_fault), .line_baud(line_baud), .line_parity(line_parity),
    .line_stop2(line_stop2));

  mbs_partner i_mbs_partner (
    .clk(clk), .rst(rst), .slow(slow), .reg_req(reg_req), .reg_we(reg_we),
    .reg_input(reg_input), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_fault(reg_fault),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));

  // The clock runs at 20 MHz.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [15:0] crc16(input logic [7:0] q [$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[k]) begin
      c = c ^ {8'h00, q[k]};
      for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction

  task automatic end_sim();
    if (n_fail == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // Sends one framed request, then compares the whole reply with the one worked out here.
  task automatic run(input logic [7:0] dst, input mbs_row_s r, input logic bad, input logic err);
    logic [7:0]  q [$];
    logic [7:0]  e [$];
    logic [15:0] c;
    logic [15:0] v;
    logic        acc;
    int          w;
    q = {dst, r.fc, r.a[15:8], r.a[7:0], r.n[15:8], r.n[7:0]};
    w = (r.fc == FC_WR_ONE) ? 1 : (r.fc == FC_WR_MANY) ? int'(r.n) : 0;
    if (r.fc == FC_WR_MANY) q.push_back(8'(r.n << 1));
    // A count over the limit still sends at most the limit's worth of values: a full
    // set would overflow the 256-byte frame buffer and be dropped, not refused.
    for (int i = 0; i < w && i < int'(MAX_WR) && r.fc == FC_WR_MANY; i++)
      q = {q, 8'ha5, 8'(i)};
    c = crc16(q);
    q = {q, c[7:0] ^ {7'h00, bad}, c[15:8]};
    acc = !bad && !err && (dst == NODE || dst == BCAST_ADDR);
    // A block write stops at the first refused address; earlier stores stay.
    if (acc && (r.x == 8'h00 || r.x == EXC_ADDR)) begin
      for (int i = 0; i < w && int'(r.a) + i < 128; i++)
        sh[int'(r.a) + i] = (r.fc == FC_WR_ONE) ? r.n : {8'ha5, 8'(i)};
    end
    if (acc && dst != BCAST_ADDR) begin
      if (r.x != 8'h00) e = {dst, r.fc | EXC_FLAG, r.x};
      else if (w != 0) e = q[0:5];
      else begin
        e = {dst, r.fc, 8'(r.n << 1)};
        for (int i = 0; i < int'(r.n); i++) begin
          v = (r.fc == FC_RD_IN) ? ((r.a + 16'(i)) ^ 16'h5a00) : sh[int'(r.a) + i];
          e = {e, v[15:8], v[7:0]};
        end
      end
      c = crc16(e);
      e = {e, c[7:0], c[15:8]};
    end
    slow = r.slow;
    i_mbs_partner.got.delete();
    i_mbs_partner.max_gap = 0;
    foreach (q[k]) begin
      @(posedge clk);
      #2;
      rx_data  = q[k];
      rx_valid = 1'b1;
      rx_err   = err && (k == 2);
    end
    @(posedge clk);
    #2;
    rx_valid = 1'b0;
    rx_err   = 1'b0;
    rx_data  = ~rx_data;
    // Flags are read just after the edge, once the design has settled.
    for (int t = 0; t < 1000 && !tx_busy; t++) begin
      @(posedge clk);
      #2;
    end
    for (int t = 0; t < 4000 && (tx_busy || tx_valid); t++) begin
      @(posedge clk);
      #2;
    end
    repeat (4) @(posedge clk);
    chk(16'(i_mbs_partner.got.size()), 16'(e.size()));
    foreach (e[k]) begin
      if (k < i_mbs_partner.got.size())
        chk({8'h00, i_mbs_partner.got[k]}, {8'h00, e[k]});
    end
    if (!r.slow && e.size() > 1) chk(16'(i_mbs_partner.max_gap), 16'h0001);
  endtask

  // A hang is cut short well past the longest expected run.
  initial begin
    cyc = 0;
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc > 30000) begin
        n_fail++;
        end_sim();
      end
    end
  end

  // Reset checks, the table of cases, then the awkward cases by hand.
  initial begin
    rst = 1'b1;
    slow = 1'b0;
    rx_data = 8'h00;
    rx_valid = 1'b0;
    rx_err = 1'b0;
    n_fail = 0;
    compares = 0;
    for (int i = 0; i < 128; i++) sh[i] = 16'h0000;
    repeat (8) @(posedge clk);
    #2;
    rst = 1'b0;
    chk(line_baud, LINE_BAUD_DEF);
    chk({14'h0000, line_parity}, {14'h0000, PARITY_EVEN});
    chk({15'h0000, line_stop2}, {15'h0000, STOP_ONE});
    chk({14'h0000, tx_valid, reg_req}, 16'h0000);
    for (int i = 0; i < 13; i++) run(NODE, ROWS[i], 1'b0, 1'b0);
    run(NODE + 8'h01, ROWS[0], 1'b0, 1'b0);
    run(NODE, ROWS[0], 1'b1, 1'b0);
    run(NODE, ROWS[0], 1'b0, 1'b1);
    // A broadcast write lands silently; the read-back shows it.
    run(BCAST_ADDR, '{FC_WR_ONE, 16'h0009, 16'h0a0a, 8'h00, 1'b0}, 1'b0, 1'b0);
    run(NODE, '{FC_RD_HOLD, 16'h0008, 16'h0002, 8'h00, 1'b0}, 1'b0, 1'b0);
    // A read sent to everyone would collide on the line, so it gets no answer.
    run(BCAST_ADDR, ROWS[0], 1'b0, 1'b0);
    // A reset in mid-frame must drop the partial request.
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      #2;
      rx_data  = NODE;
      rx_valid = 1'b1;
    end
    @(posedge clk);
    #2;
    rx_valid = 1'b0;
    rst = 1'b1;
    @(posedge clk);
    #2;
    rst = 1'b0;
    chk({13'h0000, tx_valid, tx_busy, reg_req}, 16'h0000);
    run(NODE, ROWS[0], 1'b0, 1'b0);
    end_sim();
  end
endmodule
